//--- intc_flag_pkg.sv
/*
 * Constants, register map and carrier types shared by the interrupt flag and
 * enable block and its source arbiter.
 * Assumes one bank of 32 sources and a register port clocked by ref_clk.
 */
package intc_flag_pkg;

    localparam int unsigned NUM_SRC    = 32;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned PRI_W      = 3;
    localparam int unsigned NUM_W      = 8;
    localparam int unsigned PRI_REGS   = 8;
    localparam int unsigned SRC_PER_PR = 4;

    // Register offsets (byte addresses).
    localparam logic [ADDR_W-1:0] OFS_CONTROL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_RELOAD    = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_FLAGS     = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_ENABLES   = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_PRI_BASE  = 8'h50;
    localparam logic [ADDR_W-1:0] OFS_PRI_LAST  = 8'h6c;
    localparam logic [ADDR_W-1:0] OFS_EVT_STAT  = 8'h70;
    localparam logic [ADDR_W-1:0] OFS_EVT_MASK  = 8'h74;

    // Control register fields.
    localparam int unsigned CTL_MULTIVECTOR_SELECT_BIT  = 12;
    localparam int unsigned CTL_THR_LSB   = 8;

    // Service status register fields.
    localparam int unsigned STAT_PRI_LSB  = 8;
    localparam int unsigned STAT_NUM_LSB  = 0;

    // Priority register: field of slot k starts at k*PRI_STRIDE + PRI_LSB.
    localparam int unsigned PRI_STRIDE    = 8;
    localparam int unsigned PRI_LSB       = 2;

    // Event status bits.
    localparam int unsigned EVT_W         = 3;
    localparam int unsigned EVT_PRESENT   = 0;
    localparam int unsigned EVT_SERVICED  = 1;
    localparam int unsigned EVT_TIMER     = 2;

    // Values after reset.
    localparam logic [DATA_W-1:0] RST_WORD  = 32'h0000_0000;
    localparam logic [PRI_W-1:0]  RST_PRI   = 3'h0;
    localparam logic [NUM_W-1:0]  RST_NUM   = 8'h00;
    localparam logic [EVT_W-1:0]  RST_EVT   = 3'h0;
    localparam logic [PRI_W-1:0]  PRI_OFF   = 3'h0;
    localparam logic [PRI_W-1:0]  THR_OFF   = 3'h0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    typedef struct packed {
        logic             valid;
        logic [NUM_W-1:0] num;
        logic [PRI_W-1:0] pri;
    } present_t;

    typedef struct packed {
        logic              load;
        logic [DATA_W-1:0] value;
    } timer_load_t;

endpackage

//--- intc_src_arbiter.sv
/*
 * Picks the pending source with the highest priority level.
 * Assumes flags, enables and priorities come from the same clock domain.
 */
`timescale 1ns/10ps
module intc_src_arbiter (
    input  wire logic [intc_flag_pkg::NUM_SRC-1:0]                        flags,
    input  wire logic [intc_flag_pkg::NUM_SRC-1:0]                        enables,
    input  wire logic [intc_flag_pkg::NUM_SRC-1:0][intc_flag_pkg::PRI_W-1:0] pri,
    output intc_flag_pkg::present_t                                       pick
);
    import intc_flag_pkg::*;

    logic [NUM_SRC-1:0] eligible;

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_elig
            // Forward only when flagged, enabled and given a nonzero priority.
            assign eligible[g] = flags[g] & enables[g] & (pri[g] != PRI_OFF);
        end
    endgenerate

    // Higher level wins; on a tie the lower source number wins.
    always_comb begin
        pick = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (eligible[i] && (!pick.valid || pri[i] > pick.pri)) begin
                pick.valid = 1'b1;
                pick.num   = NUM_W'(i);
                pick.pri   = pri[i];
            end
        end
    end

endmodule // intc_src_arbiter

//--- intc_flag_enable.sv
/*
 * Interrupt request flags, enables, priorities, service status and proximity
 * timer reload, reached over a simple strobe register port.
 * Assumes peripheral requests, core acknowledge and the register master all
 * run on ref_clk; the proximity timer counter lives outside and takes loads.
 */
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////

// Contract
// - Service status bits 31 to 11 read zero and ignore writes.
// - Status bits 10:8 hold latest presented priority, hardware-updated, reset zero; the code updates them only in single vector mode.
// - Status bits 7:0 hold last serviced request number, hardware-updated, reset zero.
// - Reload register is 32-bit read/write, reset zero, loaded into timer on trigger.
// - Flag register has one read/write bit per source, set on request, reset zero.
// - Enable register has one read/write bit per source, reset zero.
// - Control bit selects multivector when set, single vector when clear.
// - Threshold field starts timer for priorities at or below it; zero disables.
// - Source priority zero blocks the source; one to seven set its level.
module intc_flag_enable (
    input  wire logic                                  ref_clk,
    input  wire logic                                  reset,
    input  intc_flag_pkg::reg_req_t                    bus_req,
    output logic [intc_flag_pkg::DATA_W-1:0]           bus_rdata,
    input  wire logic [intc_flag_pkg::NUM_SRC-1:0]     src_request,
    input  wire logic                                  core_service_ack,
    output intc_flag_pkg::present_t                    core_request,
    output intc_flag_pkg::timer_load_t                 timer_load,
    output logic                                       irq_out
);
    import intc_flag_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    logic                                multivector_select_ff;
    logic [PRI_W-1:0]                    proximity_threshold_ff;
    logic [PRI_W-1:0]                    latest_presented_priority_ff;
    logic [NUM_W-1:0]                    last_serviced_request_number_ff;
    logic [DATA_W-1:0]                   proximity_timer_reload_ff;
    logic [NUM_SRC-1:0]                  request_flag_ff;
    logic [NUM_SRC-1:0]                  source_enable_ff;
    logic [NUM_SRC-1:0][PRI_W-1:0]       source_priority_ff;
    logic [EVT_W-1:0]                    evt_status_ff;
    logic [EVT_W-1:0]                    evt_mask_ff;
    logic [DATA_W-1:0]                   rdata_ff;
    present_t                            present_ff;
    timer_load_t                         timer_load_ff;
    logic                                irq_ff;

    logic                                wr_control;
    logic                                wr_reload;
    logic                                wr_flags;
    logic                                wr_enables;
    logic                                wr_evt_stat;
    logic                                wr_evt_mask;
    logic                                pri_hit;
    logic [2:0]                          pri_index;
    present_t                            pick;
    logic                                new_present;
    logic                                timer_trigger;
    logic [EVT_W-1:0]                    evt_set;
    logic [NUM_SRC-1:0]                  nxt_request_flag;
    logic [DATA_W-1:0]                   nxt_rdata;
    logic [DATA_W-1:0]                   status_word;
    logic [DATA_W-1:0]                   control_word;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.

    assign wr_control  = bus_req.wr && bus_req.addr == OFS_CONTROL;
    assign wr_reload   = bus_req.wr && bus_req.addr == OFS_RELOAD;
    assign wr_flags    = bus_req.wr && bus_req.addr == OFS_FLAGS;
    assign wr_enables  = bus_req.wr && bus_req.addr == OFS_ENABLES;
    assign wr_evt_stat = bus_req.wr && bus_req.addr == OFS_EVT_STAT;
    assign wr_evt_mask = bus_req.wr && bus_req.addr == OFS_EVT_MASK;
    // The priority window holds eight word registers; a misaligned address in
    // that range falls through to the unmapped case and reads zero.
    assign pri_hit     = bus_req.addr >= OFS_PRI_BASE && bus_req.addr <= OFS_PRI_LAST
                         && bus_req.addr[1:0] == 2'h0;
    assign pri_index   = 3'((bus_req.addr - OFS_PRI_BASE) >> 2);

    ////////////////////////////////////////////////////////////////////////////
    // Configuration.
    // The threshold field shares the control word with the vector mode bit;
    // a write always replaces both, so software writes the whole word.

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            multivector_select_ff  <= 1'b0;
            proximity_threshold_ff <= THR_OFF;
        end else if (wr_control) begin
            multivector_select_ff  <= bus_req.wdata[CTL_MULTIVECTOR_SELECT_BIT];
            proximity_threshold_ff <= bus_req.wdata[CTL_THR_LSB +: PRI_W];
        end
    end

    // The reload word is only stored here; the timer counter outside takes a
    // copy of it with each load pulse.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            proximity_timer_reload_ff <= RST_WORD;
        end else if (wr_reload) begin
            proximity_timer_reload_ff <= bus_req.wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            source_enable_ff <= '0;
        end else if (wr_enables) begin
            source_enable_ff <= bus_req.wdata;
        end
    end

    // Each source owns one three-bit field; four sources share a register and
    // the bits between the fields are not stored, so they read zero.
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_pri
            localparam int unsigned REG_IDX = g / SRC_PER_PR;
            localparam int unsigned FLD_LSB = (g % SRC_PER_PR) * PRI_STRIDE + PRI_LSB;
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    source_priority_ff[g] <= RST_PRI;
                end else if (bus_req.wr && pri_hit && pri_index == 3'(REG_IDX)) begin
                    source_priority_ff[g] <= bus_req.wdata[FLD_LSB +: PRI_W];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Request flags: a peripheral request wins over a software clear.
    // A software write replaces the whole flag word. A source that requests in
    // the same cycle still sets its bit, so no request is lost to a clear that
    // was meant for an older one.

    always_comb begin
        nxt_request_flag = wr_flags ? bus_req.wdata : request_flag_ff;
        nxt_request_flag = nxt_request_flag | src_request;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            request_flag_ff <= '0;
        end else begin
            request_flag_ff <= nxt_request_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Presentation to the core.

    // The arbiter looks at registered flags, so a request reaches the core two
    // cycles after the source raises it.
    intc_src_arbiter u_arbiter (
        .flags   (request_flag_ff),
        .enables (source_enable_ff),
        .pri     (source_priority_ff),
        .pick    (pick)
    );

    // A presentation counts as new when the pick appears or changes source or
    // level; a steady pick raises no further events and no further loads.
    assign new_present   = pick.valid && (!present_ff.valid || pick.num != present_ff.num
                                          || pick.pri != present_ff.pri);
    assign timer_trigger = new_present && proximity_threshold_ff != THR_OFF
                           && pick.pri <= proximity_threshold_ff;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            present_ff <= '0;
        end else begin
            present_ff <= pick;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            timer_load_ff <= '0;
        end else begin
            timer_load_ff.load  <= timer_trigger;
            timer_load_ff.value <= proximity_timer_reload_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Service status.

    // In multivector mode the latest priority holds its last value; software
    // must not read meaning into it then.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            latest_presented_priority_ff <= RST_PRI;
        end else if (new_present && !multivector_select_ff) begin
            latest_presented_priority_ff <= pick.pri;
        end
    end

    // An acknowledge without a presented request is ignored, so a stray pulse
    // cannot store a stale number.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            last_serviced_request_number_ff <= RST_NUM;
        end else if (core_service_ack && present_ff.valid) begin
            last_serviced_request_number_ff <= present_ff.num;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event status and interrupt; a new event wins over a write-one clear.

    // Bit 0 marks a new presentation, bit 1 a service and bit 2 a timer load.
    always_comb begin
        evt_set               = '0;
        evt_set[EVT_PRESENT]  = new_present;
        evt_set[EVT_SERVICED] = core_service_ack && present_ff.valid;
        evt_set[EVT_TIMER]    = timer_trigger;
    end

    // Clearing a bit with a write of one loses to an event in the same cycle,
    // so an event that lands during the clear is still reported.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            evt_status_ff <= RST_EVT;
        end else begin
            evt_status_ff <= (evt_status_ff & ~(wr_evt_stat ? bus_req.wdata[EVT_W-1:0] : RST_EVT))
                             | evt_set;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            evt_mask_ff <= RST_EVT;
        end else if (wr_evt_mask) begin
            evt_mask_ff <= bus_req.wdata[EVT_W-1:0];
        end
    end

    // The interrupt follows the masked status one cycle late, since it comes
    // from a flip-flop.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(evt_status_ff & evt_mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path; unmapped addresses read zero.

    // The status word is built from constants and the two hardware fields,
    // so the unused upper bits can never carry anything but zero.
    always_comb begin
        status_word = RST_WORD;
        status_word[STAT_PRI_LSB +: PRI_W] = latest_presented_priority_ff;
        status_word[STAT_NUM_LSB +: NUM_W] = last_serviced_request_number_ff;
        control_word = RST_WORD;
        control_word[CTL_MULTIVECTOR_SELECT_BIT] = multivector_select_ff;
        control_word[CTL_THR_LSB +: PRI_W] = proximity_threshold_ff;
    end

    // Reads have no side effects; a read of the flags does not clear them.
    always_comb begin
        nxt_rdata = RST_WORD;
        if (pri_hit) begin
            for (int k = 0; k < SRC_PER_PR; k++) begin
                nxt_rdata[k*PRI_STRIDE + PRI_LSB +: PRI_W] =
                    source_priority_ff[int'(pri_index) * SRC_PER_PR + k];
            end
        end else begin
            case (bus_req.addr)
                OFS_CONTROL:  nxt_rdata = control_word;
                OFS_STATUS:   nxt_rdata = status_word;
                OFS_RELOAD:   nxt_rdata = proximity_timer_reload_ff;
                OFS_FLAGS:    nxt_rdata = request_flag_ff;
                OFS_ENABLES:  nxt_rdata = source_enable_ff;
                OFS_EVT_STAT: nxt_rdata[EVT_W-1:0] = evt_status_ff;
                OFS_EVT_MASK: nxt_rdata[EVT_W-1:0] = evt_mask_ff;
                default:      nxt_rdata = RST_WORD;
            endcase
        end
    end

    // Read data stand for exactly the cycle after the strobe.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_ff <= RST_WORD;
        end else if (bus_req.rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= RST_WORD;
        end
    end

    assign bus_rdata    = rdata_ff;
    assign core_request = present_ff;
    assign timer_load   = timer_load_ff;
    assign irq_out      = irq_ff;

endmodule // intc_flag_enable

//--- intc_flag_enable_props.sv
/* Checker for the interrupt flag and enable block.
   Assumes it sees only the top ports, one clock and a synchronous reset. */
`timescale 1ns/10ps
module intc_flag_enable_props (
    input wire logic                              ref_clk,
    input wire logic                              reset,
    input intc_flag_pkg::reg_req_t                bus_req,
    input wire logic [intc_flag_pkg::DATA_W-1:0]  bus_rdata,
    input wire logic [intc_flag_pkg::NUM_SRC-1:0] src_request,
    input wire logic                              core_service_ack,
    input intc_flag_pkg::present_t                core_request,
    input intc_flag_pkg::timer_load_t             timer_load,
    input wire logic                              irq_out
);
    import intc_flag_pkg::*;
    logic [NUM_W-1:0]  num_ff;
    logic [DATA_W-1:0] reload_ff;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Shadow copies of the serviced number and the reload word.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            num_ff <= RST_NUM;
        end else if (core_service_ack && core_request.valid) begin
            num_ff <= core_request.num;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reload_ff <= RST_WORD;
        end else if (bus_req.wr && bus_req.addr == OFS_RELOAD) begin
            reload_ff <= bus_req.wdata;
        end
    end
    a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == '0)
        else $error("read data not zero outside a read");
    a_status_high: assert property ($past(bus_req.rd && bus_req.addr == OFS_STATUS) |-> bus_rdata[31:11] == '0)
        else $error("status upper bits not zero");
    a_serviced_num: assert property ($past(bus_req.rd && bus_req.addr == OFS_STATUS)
        |-> bus_rdata[7:0] == $past(num_ff))
        else $error("status number differs from last serviced");
    a_reload_read: assert property ($past(bus_req.rd && bus_req.addr == OFS_RELOAD)
        |-> bus_rdata == $past(reload_ff))
        else $error("reload readback differs");
    a_load_value: assert property (timer_load.load |-> timer_load.value == $past(reload_ff))
        else $error("timer load value differs from reload");
    a_load_cause: assert property (timer_load.load |-> core_request.valid && core_request != $past(core_request))
        else $error("timer load without new presentation");
    a_present_pri: assert property (core_request.valid |-> core_request.pri != PRI_OFF)
        else $error("presented request has priority zero");
    a_flag_sets: assert property ($past(bus_req.rd && bus_req.addr == OFS_FLAGS)
        |-> (bus_rdata & $past(src_request, 2)) == $past(src_request, 2))
        else $error("request did not set its flag");
endmodule // intc_flag_enable_props

bind intc_flag_enable intc_flag_enable_props u_intc_flag_enable_props (
    .ref_clk(ref_clk), .reset(reset), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .src_request(src_request), .core_service_ack(core_service_ack),
    .core_request(core_request), .timer_load(timer_load), .irq_out(irq_out));

//--- intc_core_model.sv
/* Processor core model that services a presented request once each time valid rises.
   Assumes the presented request comes registered on ref_clk. */
`timescale 1ns/10ps
module intc_core_model (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  intc_flag_pkg::present_t core_request,
    input  wire logic [3:0]        ack_wait,
    output logic                   core_service_ack
);
    import intc_flag_pkg::*;
    logic [3:0] wait_ff;
    logic       done_ff;
    // A slow core idles ack_wait cycles before it services the request.
    always_ff @(posedge ref_clk) begin
        if (reset || !core_request.valid) begin
            wait_ff <= 4'h0;
            done_ff <= 1'b0;
            core_service_ack <= 1'b0;
        end else if (!done_ff && wait_ff == ack_wait) begin
            core_service_ack <= 1'b1;
            done_ff <= 1'b1;
        end else begin
            core_service_ack <= 1'b0;
            wait_ff <= done_ff ? wait_ff : wait_ff + 4'h1;
        end
    end
endmodule // intc_core_model

//--- intc_flag_enable_tb_top.sv
/* Self-checking bench for the interrupt flag and enable block.
   Assumes the core model answers presentations and the bench is bus master. */
`timescale 1ns/10ps
module intc_flag_enable_tb_top;
    import intc_flag_pkg::*;
    logic                ref_clk = 1'b0;
    logic                reset;
    reg_req_t            bus_req;
    logic [DATA_W-1:0]   bus_rdata;
    logic [NUM_SRC-1:0]  src_request;
    logic                core_service_ack;
    present_t            core_request;
    timer_load_t         timer_load;
    logic                irq_out;
    logic [3:0]          ack_wait;
    logic [DATA_W-1:0]   load_val = '0;
    int                  load_cnt = 0;
    int                  num_errors = 0;
    int                  compares = 0;
    intc_flag_enable u_intc_flag_enable (.ref_clk(ref_clk), .reset(reset), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .src_request(src_request), .core_service_ack(core_service_ack),
        .core_request(core_request), .timer_load(timer_load), .irq_out(irq_out));
    intc_core_model u_intc_core_model (.ref_clk(ref_clk), .reset(reset), .core_request(core_request),
        .ack_wait(ack_wait), .core_service_ack(core_service_ack));
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (timer_load.load === 1'b1) begin
            load_cnt <= load_cnt + 1;
            load_val <= timer_load.value;
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rchk(input string n, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1 chk(n, e, bus_rdata);
    endtask
    task automatic pulse_src(input logic [NUM_SRC-1:0] m);
        @(posedge ref_clk);
        src_request <= m;
        @(posedge ref_clk);
        src_request <= '0;
    endtask
    task automatic wait_valid(input logic v);
        for (int i = 0; i < 40 && core_request.valid !== v; i++) begin
            @(posedge ref_clk);
            #1;
        end
        chk("valid", {31'h0, v}, {31'h0, core_request.valid});
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_reset();
        rchk("status", OFS_STATUS, RST_WORD);
        rchk("reload", OFS_RELOAD, RST_WORD);
        rchk("flags", OFS_FLAGS, RST_WORD);
        rchk("enables", OFS_ENABLES, RST_WORD);
        rchk("control", OFS_CONTROL, RST_WORD);
    endtask
    task automatic t_regs();
        bus_wr(OFS_STATUS, 32'hffff_ffff);
        rchk("status", OFS_STATUS, RST_WORD);
        rchk("unmapped", 8'hf0, RST_WORD);
        bus_wr(OFS_RELOAD, 32'ha5a5_5a5a);
        rchk("reload", OFS_RELOAD, 32'ha5a5_5a5a);
        bus_wr(OFS_FLAGS, 32'h8000_0001);
        rchk("flags", OFS_FLAGS, 32'h8000_0001);
        bus_wr(OFS_ENABLES, 32'h5a5a_a5a5);
        rchk("enables", OFS_ENABLES, 32'h5a5a_a5a5);
        bus_wr(OFS_FLAGS, 32'h0);
        bus_wr(OFS_ENABLES, 32'h0);
    endtask
    task automatic t_present();
        bus_wr(OFS_ENABLES, 32'h0000_0224);
        bus_wr(OFS_RELOAD, 32'h1234_abcd);
        bus_wr(OFS_CONTROL, 32'h0000_0300);
        bus_wr(8'h54, 32'h0000_0c00);
        pulse_src(32'h4);
        repeat (5) @(posedge ref_clk);
        wait_valid(1'b0);
        rchk("flags", OFS_FLAGS, 32'h4);
        pulse_src(32'h20);
        wait_valid(1'b1);
        chk("num", 32'h5, {24'h0, core_request.num});
        chk("pri", 32'h3, {29'h0, core_request.pri});
        repeat (4) @(posedge ref_clk);
        chk("loads", 32'h1, load_cnt);
        chk("load value", 32'h1234_abcd, load_val);
        rchk("status", OFS_STATUS, 32'h0000_0305);
        rchk("events", OFS_EVT_STAT, 32'h7);
        bus_wr(OFS_EVT_MASK, 32'h2);
        @(posedge ref_clk);
        #1 chk("irq on", 32'h1, {31'h0, irq_out});
        bus_wr(OFS_EVT_STAT, 32'h2);
        @(posedge ref_clk);
        #1 chk("irq cleared", 32'h0, {31'h0, irq_out});
        rchk("events", OFS_EVT_STAT, 32'h5);
        rchk("mask", OFS_EVT_MASK, 32'h2);
        rchk("priority", 8'h54, 32'h0000_0c00);
        bus_wr(OFS_ENABLES, 32'h0);
        wait_valid(1'b0);
        bus_wr(OFS_FLAGS, 32'h0);
        bus_wr(OFS_EVT_STAT, 32'h7);
    endtask
    task automatic t_multivector_select();
        ack_wait <= 4'h5;
        bus_wr(OFS_CONTROL, 32'h0000_1000);
        bus_wr(8'h58, 32'h0000_1800);
        bus_wr(OFS_ENABLES, 32'h0000_0200);
        pulse_src(32'h200);
        wait_valid(1'b1);
        chk("num", 32'h9, {24'h0, core_request.num});
        repeat (12) @(posedge ref_clk);
        rchk("status", OFS_STATUS, 32'h0000_0309);
        rchk("control", OFS_CONTROL, 32'h0000_1000);
        rchk("priority", 8'h58, 32'h0000_1800);
        chk("loads", 32'h1, load_cnt);
    endtask
    task automatic t_rerun();
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        chk("valid", 32'h0, {31'h0, core_request.valid});
    endtask
    task automatic end_sim();
        if (num_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        bus_req = '0;
        src_request = '0;
        ack_wait = 4'h0;
        reset = 1'b1;
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_regs();
        t_present();
        t_multivector_select();
        t_rerun();
        end_sim();
    end
    initial begin
        #20000;
        num_errors++;
        end_sim();
    end
endmodule // intc_flag_enable_tb_top
